// ==== shared/i2c_resp_regs.vh ====
// Register map and field constants of the slave response control block
`ifndef I2C_RESP_REGS_VH
`define I2C_RESP_REGS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_SLAVE_DATA_FORCE_DATA_A_CTRL   12'h0084
`define OFS_SDA_SETUP_DELAY        12'h0094
`define OFS_GENERAL_CALL_ACK_CTRL  12'h0098
`define OFS_RESP_STATUS            12'h00A0

// ****************************************************************
// Field widths, positions and reset values
// ****************************************************************
`define ADDR_W                     12
`define SETUP_W                    8
`define SETUP_RST                  8'h00
`define BIT_RST                    1'b0
`define ZERO_WORD                  32'h0000_0000
`define SETUP_ONE                  8'h01
`define SETUP_ZERO                 8'h00
`define STAT_W                     4
`define SEL_W                      4
`define SEL_FORCE_DATA_A                   0
`define SEL_SETUP                  1
`define SEL_GCALL                  2
`define SEL_STAT                   3
`define CTRL_BIT                   0
`define BYTE_ZERO                  8'h00

`endif

// ==== logic/i2c_slave_response_control.v ====
// Slave-side ACK/FORCE_DATA_A, general call and SDA setup hold control with APB registers
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps

`include "i2c_resp_regs.vh"

module i2c_slave_response_control (
  // Clock and reset
  input  wire                   mclk,
  input  wire                   rst_b,
  // APB slave
  input  wire                   psel,
  input  wire                   penable,
  input  wire                   pwrite,
  input  wire [`ADDR_W-1:0]     paddr,
  input  wire [31:0]            pwdata,
  output reg  [31:0]            prdata,
  output reg                    pready,
  output reg                    pslverr,
  // Controller core state
  input  wire                   ctrl_enable,
  input  wire                   slave_mode,
  input  wire                   slave_active,
  input  wire                   slave_rx_mode,
  input  wire                   slave_tx_mode,
  // Received byte and address events from the slave engine
  input  wire                   data_byte_done,
  input  wire [7:0]             rx_byte,
  input  wire                   normal_ack,
  input  wire                   gcall_addr_done,
  input  wire                   ack_slot_end,
  input  wire                   sda_changed,
  // Responses to the slave engine
  output reg                    ack_valid,
  output reg                    ack_force_data_a,
  output reg                    sda_output_enable,
  output reg                    rx_push,
  output reg  [7:0]             rx_push_data,
  output reg                    gcall_irq,
  output reg                    scl_hold_low
);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  reg                   rst_meta_b;
  reg                   rst_sync_b;

  // Two-stage release of the asynchronous reset
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  // ****************************************************************
  // Register file
  // ****************************************************************
  reg                   force_data_force_data_a_bit;
  reg                   general_call_ack_bit;
  reg  [`SETUP_W-1:0]   sda_setup_delay;
  reg                   next_force_data_force_data_a_bit;
  reg                   next_general_call_ack_bit;
  reg  [`SETUP_W-1:0]   next_sda_setup_delay;
  reg  [31:0]           next_prdata;
  reg                   next_pslverr;

  wire                  apb_setup;
  wire                  apb_write;
  wire [`SEL_W-1:0]     reg_sel;
  wire                  force_data_a_write_open;
  wire                  setup_write_open;
  wire [`STAT_W-1:0]    status_bits;

  // One-hot register select, shared by write gating, read mux and error answer
  function [`SEL_W-1:0] reg_select;
    input [`ADDR_W-1:0] a;
    begin
      reg_select = {`SEL_W{1'b0}};
      if (a == `OFS_SLAVE_DATA_FORCE_DATA_A_CTRL) begin
        reg_select[`SEL_FORCE_DATA_A] = 1'b1;
      end
      if (a == `OFS_SDA_SETUP_DELAY) begin
        reg_select[`SEL_SETUP] = 1'b1;
      end
      if (a == `OFS_GENERAL_CALL_ACK_CTRL) begin
        reg_select[`SEL_GCALL] = 1'b1;
      end
      if (a == `OFS_RESP_STATUS) begin
        reg_select[`SEL_STAT] = 1'b1;
      end
    end
  endfunction

  // One control bit at its field, reserved bits zero
  function [31:0] pad_bit;
    input b;
    begin
      pad_bit            = `ZERO_WORD;
      pad_bit[`CTRL_BIT] = b;
    end
  endfunction

  // Bus phase, decode, write locks and status word
  assign apb_setup        = psel & ~penable;
  assign apb_write        = psel & penable & pwrite;
  assign reg_sel          = reg_select(paddr);
  assign force_data_a_write_open  = ~ctrl_enable & ~slave_active;
  assign setup_write_open = ~ctrl_enable;
  assign status_bits      = {scl_hold_low, sda_output_enable, slave_active, ctrl_enable};

  // Next register values; a locked write leaves the old value in place
  always @* begin
    next_force_data_force_data_a_bit  = force_data_force_data_a_bit;
    next_sda_setup_delay      = sda_setup_delay;
    next_general_call_ack_bit = general_call_ack_bit;
    if (apb_write) begin
      if (reg_sel[`SEL_FORCE_DATA_A] && force_data_a_write_open) begin
        next_force_data_force_data_a_bit = pwdata[`CTRL_BIT];
      end
      if (reg_sel[`SEL_SETUP] && setup_write_open) begin
        next_sda_setup_delay = pwdata[`SETUP_W-1:0];
      end
      if (reg_sel[`SEL_GCALL]) begin
        next_general_call_ack_bit = pwdata[`CTRL_BIT];
      end
    end
  end

  // Data FORCE_DATA_A control bit
  always @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      force_data_force_data_a_bit <= `BIT_RST;
    end else begin
      force_data_force_data_a_bit <= next_force_data_force_data_a_bit;
    end
  end

  // SDA setup delay field
  always @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      sda_setup_delay <= `SETUP_RST;
    end else begin
      sda_setup_delay <= next_sda_setup_delay;
    end
  end

  // General call acknowledge bit
  always @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      general_call_ack_bit <= `BIT_RST;
    end else begin
      general_call_ack_bit <= next_general_call_ack_bit;
    end
  end

  // Read data and error answer prepared in the setup cycle, zero wait states
  always @* begin
    next_prdata  = prdata;
    next_pslverr = pslverr;
    if (apb_setup) begin
      next_pslverr = ~|reg_sel;
      if (reg_sel[`SEL_FORCE_DATA_A]) begin
        next_prdata = pad_bit(force_data_force_data_a_bit);
      end else if (reg_sel[`SEL_SETUP]) begin
        next_prdata = {{(32-`SETUP_W){1'b0}}, sda_setup_delay};
      end else if (reg_sel[`SEL_GCALL]) begin
        next_prdata = pad_bit(general_call_ack_bit);
      end else if (reg_sel[`SEL_STAT]) begin
        next_prdata = {{(32-`STAT_W){1'b0}}, status_bits};
      end else begin
        next_prdata = `ZERO_WORD;
      end
    end
  end

  // Answer registers; pready stands high from one clock after reset release
  always @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      prdata  <= `ZERO_WORD;
      pready  <= `BIT_RST;
      pslverr <= `BIT_RST;
    end else begin
      prdata  <= next_prdata;
      pready  <= 1'b1;
      pslverr <= next_pslverr;
    end
  end

  // ****************************************************************
  // Acknowledge decision and receive push
  // ****************************************************************
  reg                   next_ack_valid;
  reg                   next_ack_force_data_a;
  reg                   next_sda_output_enable;
  reg                   next_rx_push;
  reg  [7:0]            next_rx_push_data;
  reg                   next_gcall_irq;

  wire                  force_applies;
  wire                  gcall_taken;

  // Forcing needs the receiver role, general call needs slave mode
  assign force_applies = slave_rx_mode & force_data_force_data_a_bit;
  assign gcall_taken   = gcall_addr_done & slave_mode;

  // Data bytes win over general call; a new decision overrides the slot end
  always @* begin
    next_ack_valid         = 1'b0;
    next_ack_force_data_a          = ack_force_data_a;
    next_sda_output_enable = sda_output_enable;
    next_rx_push           = 1'b0;
    next_rx_push_data      = rx_push_data;
    next_gcall_irq         = 1'b0;
    if (ack_slot_end) begin
      next_sda_output_enable = 1'b0;
    end
    if (data_byte_done) begin
      next_ack_valid = 1'b1;
      if (force_applies) begin
        next_ack_force_data_a          = 1'b1;
        next_sda_output_enable = 1'b0;
        next_rx_push           = 1'b0;
      end else begin
        next_ack_force_data_a          = ~normal_ack;
        next_sda_output_enable = normal_ack;
        next_rx_push           = normal_ack & slave_rx_mode;
        next_rx_push_data      = rx_byte;
      end
    end else if (gcall_taken) begin
      next_ack_valid         = 1'b1;
      next_ack_force_data_a          = ~general_call_ack_bit;
      next_sda_output_enable = general_call_ack_bit;
      next_gcall_irq         = general_call_ack_bit;
    end
  end

  // Decision strobe and the FORCE_DATA_A level it carries
  always @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ack_valid <= `BIT_RST;
      ack_force_data_a  <= `BIT_RST;
    end else begin
      ack_valid <= next_ack_valid;
      ack_force_data_a  <= next_ack_force_data_a;
    end
  end

  // SDA driver enable, high while an ACK is driven
  always @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      sda_output_enable <= `BIT_RST;
    end else begin
      sda_output_enable <= next_sda_output_enable;
    end
  end

  // Receive buffer push and its byte
  always @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      rx_push      <= `BIT_RST;
      rx_push_data <= `BYTE_ZERO;
    end else begin
      rx_push      <= next_rx_push;
      rx_push_data <= next_rx_push_data;
    end
  end

  // General call interrupt strobe
  always @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      gcall_irq <= `BIT_RST;
    end else begin
      gcall_irq <= next_gcall_irq;
    end
  end

  // ****************************************************************
  // SDA setup hold of SCL
  // ****************************************************************
  reg  [`SETUP_W-1:0]   hold_count;
  reg  [`SETUP_W-1:0]   next_hold_count;
  reg                   next_scl_hold_low;

  wire                  hold_start;

  // Only a transmitter's own SDA change starts the hold
  assign hold_start = sda_changed & slave_tx_mode;

  // Hold lasts sda_setup_delay clocks; a zero delay gives no hold
  always @* begin
    next_hold_count   = `SETUP_ZERO;
    next_scl_hold_low = 1'b0;
    if (hold_start) begin
      next_hold_count   = sda_setup_delay;
      next_scl_hold_low = (sda_setup_delay != `SETUP_ZERO);
    end else if (hold_count > `SETUP_ONE) begin
      next_hold_count   = hold_count - `SETUP_ONE;
      next_scl_hold_low = scl_hold_low;
    end
  end

  // Hold counter and SCL hold output
  always @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      hold_count   <= `SETUP_ZERO;
      scl_hold_low <= `BIT_RST;
    end else begin
      hold_count   <= next_hold_count;
      scl_hold_low <= next_scl_hold_low;
    end
  end

endmodule

// ==== sim/i2c_resp_chk.sv ====
// Port assertions for the slave response control block
`timescale 1ns/1ps
module i2c_resp_chk (
  input wire mclk, rst_b, psel, penable, pwrite, pslverr, slave_mode, slave_rx_mode,
  input wire slave_tx_mode, data_byte_done, normal_ack, gcall_addr_done, sda_changed,
  input wire ack_valid, ack_force_data_a, sda_output_enable, rx_push, gcall_irq, scl_hold_low,
  input wire [31:0] prdata
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  a_push_rx_only: assert property (
    rx_push |-> $past(data_byte_done & slave_rx_mode)) else $error("push outside rx");
  a_force_data_a_no_push: assert property (
    ack_valid & ack_force_data_a |-> !rx_push) else $error("nacked byte pushed");
  a_plain_force_data_a: assert property (
    data_byte_done & !normal_ack |=> ack_valid & ack_force_data_a) else $error("force_data_a lost");
  a_role_normal: assert property (
    data_byte_done & !slave_rx_mode |=> ack_force_data_a != $past(normal_ack)) else $error("role");
  a_gcall_slave: assert property (
    gcall_addr_done & !data_byte_done & !slave_mode |=> !ack_valid) else $error("gcall");
  a_irq_ack: assert property (
    gcall_irq |-> ack_valid & !ack_force_data_a & sda_output_enable & $past(gcall_addr_done))
    else $error("irq");
  a_hold_cause: assert property (
    $rose(scl_hold_low) |-> $past(sda_changed & slave_tx_mode)) else $error("hold");
  a_resv_zero: assert property (
    psel & penable & !pwrite & !pslverr |-> prdata[31:8] == 0) else $error("reserved");
endmodule
bind i2c_slave_response_control i2c_resp_chk i_chk (.*);

// ==== sim/i2c_master_model.sv ====
// Bus-side master model sending byte, general call and SDA change events
`timescale 1ns/1ps
module i2c_master_model (
  // Requests from the bench
  input wire       mclk, go,
  input wire [1:0] kind,
  input wire [3:0] gap,
  // Events toward the design
  output reg       data_byte_done, gcall_addr_done, sda_changed, ack_slot_end
);
  // Waits gap cycles, pulses one event, then closes the ACK slot
  initial begin
    {gcall_addr_done, data_byte_done, sda_changed, ack_slot_end} = 4'h0;
    forever begin
      @(posedge mclk);
      if (go) begin
        repeat (gap) @(posedge mclk);
        {gcall_addr_done, data_byte_done, sda_changed} <= 3'h1 << kind;
        @(posedge mclk) {gcall_addr_done, data_byte_done, sda_changed} <= 3'h0;
        repeat (2) @(posedge mclk);
        ack_slot_end <= 1'b1;
        @(posedge mclk) ack_slot_end <= 1'b0;
      end
    end
  end
endmodule

// ==== sim/tb_top.sv ====
// Random and corner-case bench for the slave response control block
`timescale 1ns/1ps
`include "i2c_resp_regs.vh"
module tb_top;
  reg mclk, rst_b, psel, penable, pwrite, ctrl_enable, slave_mode, slave_active, go;
  reg slave_rx_mode, slave_tx_mode, normal_ack, err, seen, frc;
  reg [`ADDR_W-1:0] paddr;
  reg [31:0] pwdata, rd, seed;
  reg [7:0] rx_byte, setup, pdat;
  reg [1:0] kind;
  reg [3:0] gap, cap;
  wire [31:0] prdata;
  wire [7:0] rx_push_data;
  wire pready, pslverr, ack_valid, ack_force_data_a, sda_output_enable, rx_push, gcall_irq;
  wire scl_hold_low, data_byte_done, gcall_addr_done, sda_changed, ack_slot_end;
  wire [35:0] map = {`OFS_SLAVE_DATA_FORCE_DATA_A_CTRL, `OFS_SDA_SETUP_DELAY, `OFS_GENERAL_CALL_ACK_CTRL};
  integer bad_count, n_checks, i, n;
  i2c_slave_response_control i_dut (.*);
  i2c_master_model i_far (.*);
  initial begin mclk = 0; forever #25 mclk = ~mclk; end
  // Xorshift source and expected {force_data_a, drive, push} of a data byte
  function [31:0] xs; seed ^= seed << 13; seed ^= seed >> 17; seed ^= seed << 5; xs = seed;
  endfunction
  function [2:0] exp_ack(input f, r, ok); exp_ack = (f & r) ? 3'h4 : {!ok, ok, r & ok};
  endfunction
  task conclude;
    if (bad_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task chk(input [39:0] s, e, input string nm);
    n_checks += 1;
    if (s !== e) begin bad_count += 1; $display("BAD %s exp %h seen %h", nm, e, s); end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk) penable <= 1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata; err = pslverr; psel <= 0; penable <= 0;
    @(posedge mclk);
  endtask
  task ev(input [1:0] k);
    kind <= k; gap <= xs(); rx_byte <= xs(); normal_ack <= xs(); go <= 1;
    @(posedge mclk) go <= 0;
    seen = 0; n = 0;
    repeat (40) begin
      @(posedge mclk);
      n += (scl_hold_low === 1'b1);
      if (ack_valid === 1'b1 && !seen) begin seen = 1; pdat = rx_push_data;
        cap = {ack_force_data_a, sda_output_enable, rx_push, gcall_irq}; end
    end
  endtask
  initial begin
    seed = 32'h0aa3_d81a; bad_count = 0; n_checks = 0; rst_b = 0;
    {psel, penable, pwrite, ctrl_enable, slave_mode, slave_active, go} = 0;
    {slave_rx_mode, slave_tx_mode, normal_ack, kind, gap, paddr, pwdata, rx_byte} = 0;
    repeat (3) @(posedge mclk);
    rst_b <= 1;
    repeat (4) @(posedge mclk);
    // Reset values, then all ones: only defined bits stick
    for (i = 0; i < 3; i += 1) begin
      apb(0, map[i*12 +: 12], 0); chk(rd, 0, "reset");
      apb(1, map[i*12 +: 12], 32'hffff_ffff); apb(0, map[i*12 +: 12], 0);
      chk(rd, i == 1 ? 8'hff : 8'h01, "ones");
    end
    apb(0, 12'h0ffc, 0); chk({err, rd}, 33'h1_0000_0000, "unmapped");
    // Setup and force writes while enabled, and force writes while slave busy, are dropped
    ctrl_enable <= 1;
    apb(1, `OFS_SDA_SETUP_DELAY, 5); apb(1, `OFS_SLAVE_DATA_FORCE_DATA_A_CTRL, 0);
    apb(0, `OFS_SDA_SETUP_DELAY, 0); chk(rd, 8'hff, "locked");
    ctrl_enable <= 0; slave_active <= 1;
    apb(1, `OFS_SLAVE_DATA_FORCE_DATA_A_CTRL, 0);
    apb(0, `OFS_SLAVE_DATA_FORCE_DATA_A_CTRL, 0); chk(rd, 1, "busy");
    apb(0, `OFS_RESP_STATUS, 0); chk(rd, 2, "status");
    slave_active <= 0;
    // Random bytes over both roles and both force settings
    for (i = 0; i < 24; i += 1) begin
      frc = xs(); apb(1, `OFS_SLAVE_DATA_FORCE_DATA_A_CTRL, frc); slave_rx_mode <= xs(); ev(1);
      chk({seen, cap[3:1]}, {1'b1, exp_ack(frc, slave_rx_mode, normal_ack)}, "byte");
      if (cap[1]) chk(pdat, rx_byte, "data");
    end
    // General call, bit set and clear, in and out of slave mode
    for (i = 0; i < 4; i += 1) begin
      apb(1, `OFS_GENERAL_CALL_ACK_CTRL, i & 1); slave_mode <= i[1]; ev(2);
      chk(i[1] ? {seen, cap[3:2], cap[0]} : seen, i[1] ? {1'b1, !i[0], i[0], i[0]} : 0, "gc");
    end
    // SDA change as transmitter holds SCL for the programmed count
    for (i = 0; i < 6; i += 1) begin
      setup = (i == 0) ? 2 : 2 + xs() % 16;
      apb(1, `OFS_SDA_SETUP_DELAY, setup); slave_tx_mode <= (i != 5); ev(0);
      chk(n, (i != 5) ? setup : 0, "hold");
    end
    conclude;
  end
  // Cuts a hang short
  initial begin repeat (40000) @(posedge mclk); bad_count += 1; conclude; end
endmodule
